// ---- design/cfi_regs.svh ----
`ifndef CFI_REGS_SVH
`define CFI_REGS_SVH

// register offsets
`define CFI_ADDR_SYS_FLAGS   8'h08
`define CFI_ADDR_CHG_FLAGS   8'h09
`define CFI_ADDR_BST_FLAGS   8'h0A
`define CFI_ADDR_SYS_MASK    8'h0B
`define CFI_ADDR_CHG_MASK    8'h0C

// reset values
`define CFI_RST_BYTE         8'h00

// system flag positions
`define CFI_SYS_OVERTEMP     7
`define CFI_SYS_INPUT_OV     6
`define CFI_SYS_BACKLIGHT    0
// system flag bits that exist
`define CFI_SYS_USED         8'hC1
// reserved read-write bits 4:1 of the system flag register
`define CFI_SYS_RSVD_RW      8'h1E

// charger flag positions
`define CFI_CHG_REVERSE      7
`define CFI_CHG_BAD_ADAPTOR  6
`define CFI_CHG_BATT_OV      5
`define CFI_CHG_DONE         4
`define CFI_CHG_RECHARGE     3
`define CFI_CHG_TIMER        2
`define CFI_CHG_THERMAL_REG  1
`define CFI_CHG_POWER_LIMIT  0
// charger flags that are faults
`define CFI_CHG_FAULTS       8'hE4

// boost flags used, bits 7:3
`define CFI_BST_USED         8'hF8
// zero fill below the boost flags
`define CFI_BST_PAD          3'h0

// every charger mask bit exists
`define CFI_CHG_USED         8'hFF

// charger enable encodings
`define CFI_EN_OFF           2'h0
`define CFI_EN_RECHG_STOP    2'h2

`endif

// ---- design/cfi_pkg.sv ----
package cfi_pkg;

	// raw event levels from the analog monitors
	typedef struct packed {
		logic       overtemp;
		logic       input_overvolt;
		logic       backlight_overvolt;
		logic [7:0] charger;
		logic [4:0] boost;
	} cfi_events_s;

	// register access from the serial front end
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cfi_bus_s;

	typedef struct packed {
		logic [7:0] sys_flags;
		logic [7:0] chg_flags;
		logic [7:0] bst_flags;
		logic [7:0] sys_mask;
		logic [7:0] chg_mask;
		logic [7:0] rdata;
		logic [1:0] charger_enable_field;
		logic       irq;
	} cfi_state_s;

endpackage

// ---- design/cfi_flags.sv ----
`timescale 1ns/10ps
`include "cfi_regs.svh"
// Functional notes
// - set system bit 7 above shutdown temperature, clear below release.
// - set system bit 6 when input bus exceeds overvoltage threshold.
// - system bit 0 is backlight overvoltage; bits 5..1 reset to zero.
// - charger bit 7 flags reverse protection.
// - charger bit 6 flags bad adaptor below minimum input voltage.
// - charger bit 5 flags battery overvoltage while charging.
// - charger bit 2 flags the 32-minute safety timer expiry as fault.
// - charger bit 1 warns while thermal regulation limits charge.
// - charger bit 0 warns while input power limit loop is active.
// - any charger fault forces the charger enable field to off.
// - recharge request turns charger off only when enable field is 10.
// - boost bit 7 flags boost output overvoltage.
// - boost bits 6..3 flag overload, low battery, battery OV, timeout.
// - any boost fault forces the charger enable field to off.
// - system mask holds bits 7, 6, 0; one masks the event.
// - charger mask has one bit per charger flag, reset unmasked.
// - masks never stop fault detection or protective shutdown.
// - a masked flag still records but does not reach the pin.
module cfi_flags
	import cfi_pkg::*;
(
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// event levels from the monitors
	input  wire cfi_events_s events_in,
	// register access
	input  wire cfi_bus_s    bus_in,
	output logic [7:0]       rdata_out,
	// charger enable field, host writes pass through here
	input  wire logic        enable_wr_in,
	input  wire logic [1:0]  enable_wdata_in,
	output logic [1:0]       charger_enable_field_out,
	// interrupt pin
	output logic             irq_out
);

	// ****************************************
	// state
	// ****************************************
	cfi_state_s st_q;
	cfi_state_s st_d;

	// ****************************************
	// decode helpers
	// ****************************************
	// bus reads the given register this cycle
	function automatic logic rd_hit(
		input cfi_bus_s   bus,
		input logic [7:0] addr
	);
		rd_hit = bus.rd && (bus.addr == addr);
	endfunction

	// bus writes the given register this cycle
	function automatic logic wr_hit(
		input cfi_bus_s   bus,
		input logic [7:0] addr
	);
		wr_hit = bus.wr && (bus.addr == addr);
	endfunction

	// ****************************************
	// event vectors in register bit order
	// ****************************************
	function automatic logic [7:0] sys_events(
		input cfi_events_s ev
	);
		logic [7:0] v;

		v                     = `CFI_RST_BYTE;
		v[`CFI_SYS_OVERTEMP]  = ev.overtemp;
		v[`CFI_SYS_INPUT_OV]  = ev.input_overvolt;
		v[`CFI_SYS_BACKLIGHT] = ev.backlight_overvolt;
		sys_events            = v;
	endfunction

	function automatic logic [7:0] chg_events(
		input cfi_events_s ev
	);
		logic [7:0] c;
		logic [7:0] v;

		c = ev.charger;
		v = `CFI_RST_BYTE;
		v[`CFI_CHG_REVERSE]     = c[`CFI_CHG_REVERSE];
		v[`CFI_CHG_BAD_ADAPTOR] = c[`CFI_CHG_BAD_ADAPTOR];
		v[`CFI_CHG_BATT_OV]     = c[`CFI_CHG_BATT_OV];
		v[`CFI_CHG_DONE]        = c[`CFI_CHG_DONE];
		v[`CFI_CHG_RECHARGE]    = c[`CFI_CHG_RECHARGE];
		v[`CFI_CHG_TIMER]       = c[`CFI_CHG_TIMER];
		v[`CFI_CHG_THERMAL_REG] = c[`CFI_CHG_THERMAL_REG];
		v[`CFI_CHG_POWER_LIMIT] = c[`CFI_CHG_POWER_LIMIT];
		chg_events = v;
	endfunction

	// boost monitors feed bits 7:3, bits 2:0 stay zero
	function automatic logic [7:0] bst_events(
		input cfi_events_s ev
	);
		logic [7:0] v;

		v          = {ev.boost, `CFI_BST_PAD};
		bst_events = v & `CFI_BST_USED;
	endfunction

	// ****************************************
	// flag and mask updates
	// ****************************************
	// read-clear: clear reported bits, but a live event still sets
	function automatic logic [7:0] flag_next(
		input logic [7:0] cur,
		input logic [7:0] ev,
		input logic       rd_clr
	);
		flag_next = (rd_clr ? `CFI_RST_BYTE : cur) | ev;
	endfunction

	// overtemp follows its level; reserved bits 4:1 are host storage
	function automatic logic [7:0] sys_flags_next(
		input logic [7:0] cur,
		input logic [7:0] ev,
		input logic       rd_clr,
		input logic       wr,
		input logic [7:0] wdata
	);
		logic [7:0] v;

		v = flag_next(cur, ev, rd_clr) & `CFI_SYS_USED;
		v = v | (cur & `CFI_SYS_RSVD_RW);
		v[`CFI_SYS_OVERTEMP] = ev[`CFI_SYS_OVERTEMP];
		if (wr)
			v = (v & ~`CFI_SYS_RSVD_RW) | (wdata & `CFI_SYS_RSVD_RW);
		sys_flags_next = v;
	endfunction

	// a mask only gates the pin, never the flag or the protection
	function automatic logic [7:0] mask_next(
		input logic [7:0] cur,
		input logic       wr,
		input logic [7:0] wdata,
		input logic [7:0] used
	);
		mask_next = wr ? (wdata & used) : cur;
	endfunction

	// ****************************************
	// protective shutdown
	// ****************************************
	// any charger or boost event that must stop the charger
	function automatic logic must_stop(
		input logic [1:0] cur,
		input logic [7:0] chg_ev,
		input logic [7:0] bst_ev
	);
		logic chg_fault;
		logic rechg_stop;
		logic bst_fault;

		chg_fault  = |(chg_ev & `CFI_CHG_FAULTS);
		rechg_stop = chg_ev[`CFI_CHG_RECHARGE]
			&& (cur == `CFI_EN_RECHG_STOP);
		bst_fault  = |bst_ev;
		must_stop  = chg_fault | rechg_stop | bst_fault;
	endfunction

	// raw events act here, so masks cannot stop a shutdown
	function automatic logic [1:0] enable_next(
		input logic [1:0] cur,
		input logic       wr,
		input logic [1:0] wdata,
		input logic [7:0] chg_ev,
		input logic [7:0] bst_ev
	);
		// protection wins over a host write in the same cycle
		if (must_stop(cur, chg_ev, bst_ev))
			enable_next = `CFI_EN_OFF;
		else if (wr)
			enable_next = wdata;
		else
			enable_next = cur;
	endfunction

	// ****************************************
	// interrupt pin
	// ****************************************
	// one source reaches the pin while a set flag is unmasked
	function automatic logic pending(
		input logic [7:0] flags,
		input logic [7:0] mask
	);
		pending = |(flags & ~mask);
	endfunction

	// boost flags have no mask in this block and always reach the pin
	function automatic logic irq_level(
		input logic [7:0] sys_flags,
		input logic [7:0] sys_mask,
		input logic [7:0] chg_flags,
		input logic [7:0] chg_mask,
		input logic [7:0] bst_flags
	);
		logic sys_pend;
		logic chg_pend;
		logic bst_pend;

		sys_pend  = pending(sys_flags & `CFI_SYS_USED, sys_mask);
		chg_pend  = pending(chg_flags, chg_mask);
		bst_pend  = |bst_flags;
		irq_level = sys_pend | chg_pend | bst_pend;
	endfunction

	// ****************************************
	// read data
	// ****************************************
	// data comes from the value before any read-clear
	function automatic logic [7:0] read_mux(
		input cfi_state_s s,
		input logic [7:0] addr
	);
		unique case (addr)
			`CFI_ADDR_SYS_FLAGS: read_mux = s.sys_flags;
			`CFI_ADDR_CHG_FLAGS: read_mux = s.chg_flags;
			`CFI_ADDR_BST_FLAGS: read_mux = s.bst_flags;
			`CFI_ADDR_SYS_MASK:  read_mux = s.sys_mask;
			`CFI_ADDR_CHG_MASK:  read_mux = s.chg_mask;
			default:             read_mux = `CFI_RST_BYTE;
		endcase
	endfunction

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic [7:0] sys_ev;
		logic [7:0] chg_ev;
		logic [7:0] bst_ev;
		logic       rd_sys;
		logic       rd_chg;
		logic       rd_bst;
		logic       wr_sys;
		logic       wr_smask;
		logic       wr_cmask;
		// event vectors
		sys_ev   = sys_events(events_in);
		chg_ev   = chg_events(events_in);
		bst_ev   = bst_events(events_in);
		// bus decode
		rd_sys   = rd_hit(bus_in, `CFI_ADDR_SYS_FLAGS);
		rd_chg   = rd_hit(bus_in, `CFI_ADDR_CHG_FLAGS);
		rd_bst   = rd_hit(bus_in, `CFI_ADDR_BST_FLAGS);
		wr_sys   = wr_hit(bus_in, `CFI_ADDR_SYS_FLAGS);
		wr_smask = wr_hit(bus_in, `CFI_ADDR_SYS_MASK);
		wr_cmask = wr_hit(bus_in, `CFI_ADDR_CHG_MASK);
		st_d     = st_q;

		// read data holds between reads
		if (bus_in.rd)
			st_d.rdata = read_mux(st_q, bus_in.addr);

		// flag registers
		st_d.sys_flags = sys_flags_next(st_q.sys_flags, sys_ev, rd_sys,
			wr_sys, bus_in.wdata);
		st_d.chg_flags = flag_next(st_q.chg_flags, chg_ev, rd_chg);
		st_d.bst_flags = flag_next(st_q.bst_flags, bst_ev, rd_bst);

		// masks
		st_d.sys_mask  = mask_next(st_q.sys_mask, wr_smask, bus_in.wdata,
			`CFI_SYS_USED);
		st_d.chg_mask  = mask_next(st_q.chg_mask, wr_cmask, bus_in.wdata,
			`CFI_CHG_USED);

		// charger enable
		st_d.charger_enable_field = enable_next(st_q.charger_enable_field,
			enable_wr_in, enable_wdata_in, chg_ev, bst_ev);

		// pin from the new flags after masking
		st_d.irq = irq_level(st_d.sys_flags, st_d.sys_mask,
			st_d.chg_flags, st_d.chg_mask, st_d.bst_flags);
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign rdata_out                = st_q.rdata;
	assign charger_enable_field_out = st_q.charger_enable_field;
	assign irq_out                  = st_q.irq;

endmodule // cfi_flags

// ---- tb/cfi_host.sv ----
`timescale 1ns/10ps
// ***
// host side of the register access
// ***
module cfi_host
	import cfi_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic [7:0] rdata_in,
	output cfi_bus_s        bus_out
);
	initial bus_out = '0;
	task automatic access(input logic w, input logic [7:0] a, d,
		output logic [7:0] q);
		@(posedge clk_in) #1;
		bus_out = '{w, !w, a, d};
		@(posedge clk_in) #1;
		bus_out = '{1'b0, 1'b0, ~a, ~d};
		q = rdata_in;
	endtask
endmodule // cfi_host

// ---- tb/cfi_flags_assertions.sv ----
`timescale 1ns/10ps
// ***
// port checks
// ***
module cfi_flags_checker
	import cfi_pkg::*;
(
	input wire logic        clk_in,
	input wire logic        rst_in,
	input wire cfi_events_s events_in,
	input wire cfi_bus_s    bus_in,
	input wire logic [7:0]  rdata_out,
	input wire logic        enable_wr_in,
	input wire logic [1:0]  enable_wdata_in,
	input wire logic [1:0]  charger_enable_field_out,
	input wire logic        irq_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	sequence rd_at(a);
		bus_in.rd && bus_in.addr == a;
	endsequence
	chg_fault_off_a: assert property (
		|(events_in.charger & 8'hE4) |=> charger_enable_field_out == 2'h0)
		else $error("charger fault left enable on");
	bst_fault_off_a: assert property (
		|events_in.boost |=> charger_enable_field_out == 2'h0)
		else $error("boost fault left enable on");
	rechg_off_a: assert property (
		events_in.charger[3] && charger_enable_field_out == 2'h2
		|=> charger_enable_field_out == 2'h0) else $error("recharge kept on");
	rechg_keep_a: assert property (
		events_in.charger == 8'h08 && events_in.boost == 5'h0 && !enable_wr_in
		&& charger_enable_field_out == 2'h1 |=> charger_enable_field_out == 2'h1)
		else $error("recharge stopped charger");
	bst_irq_a: assert property (
		|events_in.boost |=> irq_out) else $error("boost event no irq");
	ovt_read_a: assert property (
		events_in.overtemp ##1 (events_in.overtemp and rd_at(8'h08))
		|=> rdata_out[7]) else $error("overtemp flag missing");
	ovt_clear_a: assert property (
		!events_in.overtemp ##1 (!events_in.overtemp and rd_at(8'h08))
		|=> !rdata_out[7]) else $error("overtemp flag stuck");
	sys_rsvd_a: assert property (
		rd_at(8'h08) |=> !rdata_out[5]) else $error("system bit 5 set");
	bst_unused_a: assert property (
		rd_at(8'h0A) |=> rdata_out[2:0] == 3'h0) else $error("boost low bits");
endmodule // cfi_flags_checker
bind cfi_flags cfi_flags_checker u_chk (.clk_in(clk_in), .rst_in(rst_in),
	.events_in(events_in), .bus_in(bus_in), .rdata_out(rdata_out),
	.enable_wr_in(enable_wr_in), .enable_wdata_in(enable_wdata_in),
	.charger_enable_field_out(charger_enable_field_out), .irq_out(irq_out));

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
	$display("wrong value %s expected %h seen %h", n, e, g); end end
module testbench
	import cfi_pkg::*;
;
	logic        clk_in = 0, rst_in = 1, enable_wr_in = 0, irq_out;
	logic [1:0]  enable_wdata_in = 0, charger_enable_field_out;
	logic [7:0]  rdata_out, q;
	cfi_events_s events_in = '0;
	cfi_bus_s    bus_in;
	int          error_cnt = 0, comparisons = 0;
	initial forever #4 clk_in = ~clk_in;
	cfi_host u_cfi_host (.clk_in(clk_in), .rdata_in(rdata_out), .bus_out(bus_in));
	cfi_flags u_cfi_flags (.clk_in(clk_in), .rst_in(rst_in),
		.events_in(events_in), .bus_in(bus_in), .rdata_out(rdata_out),
		.enable_wr_in(enable_wr_in), .enable_wdata_in(enable_wdata_in),
		.charger_enable_field_out(charger_enable_field_out), .irq_out(irq_out));
	task automatic rd(input logic [7:0] a, e);
		u_cfi_host.access(0, a, 8'h00, q);
		`CHK("rdata", e, q)
	endtask
	task automatic wr(input logic [7:0] a, d);
		u_cfi_host.access(1, a, d, q);
	endtask
	task automatic ev(input logic [7:0] c, input logic [4:0] b, input logic s);
		@(posedge clk_in) #1;
		events_in = '{1'b0, 1'b0, s, c, b};
		@(posedge clk_in) #1;
		events_in = '0;
	endtask
	task automatic en(input logic [1:0] v);
		@(posedge clk_in) #1;
		{enable_wr_in, enable_wdata_in} = {1'b1, v};
		@(posedge clk_in) #1;
		enable_wr_in = 0;
	endtask
	task automatic t_reset();
		for (int a = 8; a < 13; a++) rd(a[7:0], 8'h00);
		`CHK("irq", 1'b0, irq_out)
		$display("reset test done");
	endtask
	task automatic t_sys();
		{events_in.overtemp, events_in.input_overvolt} = 2'h3;
		@(posedge clk_in) #1 events_in.input_overvolt = 0;
		rd(8'h08, 8'hC0);
		events_in.overtemp = 0;
		rd(8'h08, 8'h00);
		$display("system flag test done");
	endtask
	task automatic t_mask();
		wr(8'h0B, 8'hFF);
		rd(8'h0B, 8'hC1);
		wr(8'h0C, 8'hFF);
		rd(8'h0C, 8'hFF);
		ev(8'h00, 5'h00, 1);
		`CHK("irq", 1'b0, irq_out)
		wr(8'h08, 8'hFF);
		rd(8'h08, 8'h1F);
		wr(8'h08, 8'h00);
		ev(8'h00, 5'h00, 1);
		wr(8'h0B, 8'h00);
		@(posedge clk_in) #1 `CHK("irq", 1'b1, irq_out)
		rd(8'h08, 8'h01);
		`CHK("irq", 1'b0, irq_out)
		$display("mask test done");
	endtask
	task automatic t_prot();
		en(2'h2);
		ev(8'h08, 5'h00, 0);
		`CHK("enable", 2'h0, charger_enable_field_out)
		for (int i = 0; i < 8; i++) begin
			en(2'h1);
			ev(8'h01 << i, 5'h00, 0);
			`CHK("enable", {1'b0, !(8'hE4 >> i & 1)}, charger_enable_field_out)
		end
		for (int i = 0; i < 5; i++) begin
			en(2'h1);
			ev(8'h00, 5'h01 << i, 0);
			`CHK("enable", 2'h0, charger_enable_field_out)
			`CHK("irq", 1'b1, irq_out)
		end
		rd(8'h09, 8'hFF);
		rd(8'h0A, 8'hF8);
		`CHK("irq", 1'b0, irq_out)
		$display("protection test done");
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk_in);
		#1 rst_in = 0;
		t_reset();
		t_sys();
		t_mask();
		t_prot();
		finish_test();
	end
endmodule // testbench
